// ---- verilog/lcd_pkg.sv ----
// Constants, types and timing figures shared by the segment LCD driver.
// Assumes a 50 MHz system clock divided by 25 to stand in for the 2 MHz processor bus clock.
package lcd_pkg;

  localparam logic [7:0] CTRL_ADDR = 8'h1E;
  localparam logic [7:0] RAM_BASE = 8'h40;
  localparam logic [7:0] RAM_LAST = 8'h4B;
  localparam int RAM_BYTES = 12;
  localparam int SEG_BITS = 96;
  localparam int FP_NUM = 18;
  localparam int BP_NUM = 4;

  localparam int BIT_DISPLAY_ON = 0;
  localparam int BIT_MUX_LO = 1;
  localparam int BIT_MUX_HI = 2;
  localparam int BIT_FRAME_HALVE = 3;
  localparam int BIT_EXT_SUPPLY = 6;
  localparam logic [7:0] CTRL_RST = 8'h00;

  typedef enum logic [1:0] {
    MODE_2BP_HALF = 2'b00,
    MODE_3BP = 2'b01,
    MODE_4BP = 2'b10,
    MODE_2BP_THIRD = 2'b11
  } mux_mode_t;

  typedef struct packed {
    logic ext_supply_sel;
    logic frame_halve;
    mux_mode_t mux_sel;
    logic display_on;
  } ctrl_t;

  typedef enum logic [0:0] {
    DRV_OFF = 1'b0,
    DRV_RUN = 1'b1
  } drv_state_t;

  // Drive level codes: 0 is the lowest rail, 3 the highest.
  localparam logic [1:0] LVL_0 = 2'h0;
  localparam logic [1:0] LVL_1 = 2'h1;
  localparam logic [1:0] LVL_2 = 2'h2;
  localparam logic [1:0] LVL_3 = 2'h3;

  localparam int SYS_CLK_HZ = 50_000_000;
  localparam int BUS_HZ = 2_000_000;
  localparam int BUS_DIV = SYS_CLK_HZ / BUS_HZ;
  localparam int FRAME_HZ_2_4 = 61;
  localparam int FRAME_HZ_3 = 91;
  // Backplane slot lengths in bus-clock ticks.
  localparam int SLOT_2BP = BUS_HZ / (FRAME_HZ_2_4 * 2);
  localparam int SLOT_3BP = BUS_HZ / (FRAME_HZ_3 * 3);
  localparam int SLOT_4BP = BUS_HZ / (FRAME_HZ_2_4 * 4);

endpackage

// ---- verilog/seg_ram.sv ----
// Twelve-byte segment memory with a processor port and a driver port.
// Assumes the caller decodes addresses; contents are not cleared by reset.
`timescale 1ns/1ps
module seg_ram import lcd_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_we,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic [SEG_BITS-1:0] o_seg
);

  logic [7:0] mem [RAM_BYTES];

  // Memory keeps its contents through reset, like ordinary RAM.
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= mem[i_addr];
    end
  end

  // The driver side sees every byte at once, one cycle behind.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_seg <= '0;
    end else begin
      for (int i = 0; i < RAM_BYTES; i++) begin
        o_seg[i*8 +: 8] <= mem[i];
      end
    end
  end

endmodule // seg_ram

// ---- verilog/segment_lcd_driver.sv ----
// Multiplexed segment LCD driver: control register, segment memory and
// backplane/frontplane level sequencer. Assumes a processor bus in the
// same clock domain and an external ladder turning level codes to volts.
// Function
// - Eighteen frontplanes, four backplanes, seventy-two segments.
// - Twelve-byte segment memory in address space.
// - Byte holds two frontplanes, nibble per frontplane.
// - Set bit drives segment only when displayed.
// - Memory readable and writable while driver reads.
// - Display off: memory acts as plain RAM.
// - Bytes for frontplanes 18-23 stay plain RAM.
// - Reset gives two backplanes, half bias.
// - Reset clears display on; bit gates drivers.
// - Two select bits choose backplanes and bias.
// - Frame timing divided from bus clock.
// - Halve bit adds divide-by-two stage.
// - Backplanes repeat every two frames, data-independent.
// - Frontplanes give active segments drive each frame.
// - Three levels half bias, four third bias.
// - Driver stops during processor wait mode.
`timescale 1ns/1ps
module segment_lcd_driver import lcd_pkg::*; #(
  parameter int SLOT_2BP_P = SLOT_2BP,
  parameter int SLOT_3BP_P = SLOT_3BP,
  parameter int SLOT_4BP_P = SLOT_4BP
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_wait,
  output logic [7:0] o_rdata,
  output logic o_drv_en,
  output logic [BP_NUM-1:0][1:0] o_backplane,
  output logic [FP_NUM-1:0][1:0] o_frontplane
);

  function automatic logic [1:0] bp_count(input mux_mode_t m);
    case (m)
      MODE_3BP: bp_count = 2'd2;
      MODE_4BP: bp_count = 2'd3;
      default: bp_count = 2'd1;
    endcase
  endfunction

  function automatic logic [14:0] slot_len(input mux_mode_t m);
    case (m)
      MODE_3BP: slot_len = 15'(SLOT_3BP_P - 1);
      MODE_4BP: slot_len = 15'(SLOT_4BP_P - 1);
      default: slot_len = 15'(SLOT_2BP_P - 1);
    endcase
  endfunction

  ctrl_t ctrl_r;
  ctrl_t act_r;
  drv_state_t state_r;
  logic ram_sel;
  logic ctrl_sel;
  logic [3:0] ram_idx;
  logic [7:0] ram_rdata;
  logic [SEG_BITS-1:0] seg;
  logic [7:0] ctrl_rd_r;
  logic rd_ram_r;
  logic run;
  logic [4:0] div_cnt_r;
  logic bus_tick;
  logic halve_ph_r;
  logic slot_tick;
  logic [14:0] slot_cnt_r;
  logic [1:0] slot_idx_r;
  logic pol_r;
  logic slot_end;
  logic frame_end;
  logic [BP_NUM-1:0][1:0] bp_nxt;
  logic [FP_NUM-1:0][1:0] fp_nxt;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  assign ctrl_sel = (i_addr == CTRL_ADDR);
  assign ram_sel = (i_addr >= RAM_BASE) && (i_addr <= RAM_LAST);
  assign ram_idx = 4'(i_addr - RAM_BASE);
  assign run = ctrl_r.display_on && !i_wait;

  seg_ram seg_ram_inst (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_we(i_wr && ram_sel),
    .i_addr(ram_idx),
    .i_wdata(i_wdata),
    .o_rdata(ram_rdata),
    .o_seg(seg)
  );

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_r <= ctrl_t'(5'(CTRL_RST));
    end else if (i_wr && ctrl_sel) begin
      ctrl_r.display_on <= i_wdata[BIT_DISPLAY_ON];
      ctrl_r.mux_sel <= mux_mode_t'({i_wdata[BIT_MUX_HI],
                                     i_wdata[BIT_MUX_LO]});
      ctrl_r.frame_halve <= i_wdata[BIT_FRAME_HALVE];
      ctrl_r.ext_supply_sel <= i_wdata[BIT_EXT_SUPPLY];
    end
  end

  // Reserved bits 4, 5 and 7 always read back as zero.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_rd_r <= 8'h00;
      rd_ram_r <= 1'b0;
    end else if (i_rd) begin
      rd_ram_r <= ram_sel;
      ctrl_rd_r <= 8'h00;
      if (ctrl_sel) begin
        ctrl_rd_r[BIT_DISPLAY_ON] <= ctrl_r.display_on;
        ctrl_rd_r[BIT_MUX_LO] <= ctrl_r.mux_sel[0];
        ctrl_rd_r[BIT_MUX_HI] <= ctrl_r.mux_sel[1];
        ctrl_rd_r[BIT_FRAME_HALVE] <= ctrl_r.frame_halve;
        ctrl_rd_r[BIT_EXT_SUPPLY] <= ctrl_r.ext_supply_sel;
      end
    end
  end

  assign o_rdata = rd_ram_r ? ram_rdata : ctrl_rd_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_cnt_r <= 5'd0;
    end else if (div_cnt_r == 5'(BUS_DIV - 1)) begin
      div_cnt_r <= 5'd0;
    end else begin
      div_cnt_r <= div_cnt_r + 5'd1;
    end
  end

  assign bus_tick = (div_cnt_r == 5'(BUS_DIV - 1));

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      halve_ph_r <= 1'b0;
    end else if (bus_tick) begin
      halve_ph_r <= !halve_ph_r;
    end
  end

  assign slot_tick = (state_r == DRV_RUN) && bus_tick &&
                     (!act_r.frame_halve || halve_ph_r);
  assign slot_end = slot_tick && (slot_cnt_r == slot_len(act_r.mux_sel));
  assign frame_end = slot_end && (slot_idx_r == bp_count(act_r.mux_sel));

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= DRV_OFF;
    end else begin
      case (state_r)
        DRV_OFF: state_r <= run ? DRV_RUN : DRV_OFF;
        DRV_RUN: state_r <= run ? DRV_RUN : DRV_OFF;
        default: state_r <= DRV_OFF;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      act_r <= ctrl_t'(5'(CTRL_RST));
    end else if (state_r == DRV_OFF || frame_end) begin
      act_r <= ctrl_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      slot_cnt_r <= 15'd0;
      slot_idx_r <= 2'd0;
      pol_r <= 1'b0;
    end else if (state_r == DRV_OFF) begin
      slot_cnt_r <= 15'd0;
      slot_idx_r <= 2'd0;
      pol_r <= 1'b0;
    end else if (frame_end) begin
      slot_cnt_r <= 15'd0;
      slot_idx_r <= 2'd0;
      pol_r <= !pol_r;
    end else if (slot_end) begin
      slot_cnt_r <= 15'd0;
      slot_idx_r <= slot_idx_r + 2'd1;
    end else if (slot_tick) begin
      slot_cnt_r <= slot_cnt_r + 15'd1;
    end
  end

  // Levels are worked out for positive polarity, then mirrored about
  // the middle of the ladder on odd frames so the glass sees no DC.
  always_comb begin
    logic [1:0] top;
    logic [1:0] unsel;
    logic [1:0] off_lvl;
    logic on_bit;
    top = LVL_3;
    unsel = LVL_1;
    off_lvl = LVL_2;
    on_bit = 1'b0;
    if (act_r.mux_sel == MODE_2BP_HALF) begin
      top = LVL_2;
      off_lvl = LVL_1;
    end
    for (int b = 0; b < BP_NUM; b++) begin
      bp_nxt[b] = (2'(b) == slot_idx_r) ? top : unsel;
      if (pol_r) begin
        bp_nxt[b] = top - bp_nxt[b];
      end
    end
    for (int f = 0; f < FP_NUM; f++) begin
      on_bit = seg[f*BP_NUM + 32'(slot_idx_r)];
      fp_nxt[f] = on_bit ? LVL_0 : off_lvl;
      if (pol_r) begin
        fp_nxt[f] = top - fp_nxt[f];
      end
    end
  end

  // bytes past frontplane 17 never driven
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_drv_en <= 1'b0;
      o_backplane <= '0;
      o_frontplane <= '0;
    end else if (run && state_r == DRV_RUN) begin
      o_drv_en <= 1'b1;
      o_backplane <= bp_nxt;
      o_frontplane <= fp_nxt;
    end else begin
      o_drv_en <= 1'b0;
      o_backplane <= '0;
      o_frontplane <= '0;
    end
  end

  ctrl_write_a: assert property (i_wr && ctrl_sel |=>
    ctrl_r.mux_sel == $past(i_wdata[2:1]))
    else $error("control write not stored");

  drive_off_a: assert property (!run |=>
    !o_drv_en && o_frontplane == '0 && o_backplane == '0)
    else $error("drivers active while display off or waiting");

  wait_stop_a: assert property (i_wait |=> state_r == DRV_OFF)
    else $error("sequencer running in wait mode");

  slot_range_a: assert property (
    slot_idx_r <= bp_count(act_r.mux_sel))
    else $error("backplane slot beyond mode count");

  mode_hold_a: assert property ($changed(act_r) |->
    $past(frame_end) || $past(state_r == DRV_OFF))
    else $error("mode changed mid-frame");

  pol_flip_a: assert property ($changed(pol_r) |->
    $past(frame_end) || $past(state_r == DRV_OFF))
    else $error("polarity changed away from frame end");

  ram_rw_a: assert property ((i_wr && ram_sel) ##1
    (i_rd && ram_sel && $stable(i_addr)) |=> o_rdata == $past(i_wdata, 2))
    else $error("segment memory read mismatch");

  rsvd_zero_a: assert property (i_rd && ctrl_sel |=>
    o_rdata[7] == 1'b0 && o_rdata[5:4] == 2'b00)
    else $error("reserved control bits read nonzero");

  half_lvl_a: assert property (o_drv_en &&
    $past(act_r.mux_sel) == MODE_2BP_HALF |-> o_backplane[0] != LVL_3)
    else $error("half bias used fourth level");

endmodule // segment_lcd_driver

// ---- tb/lcd_glass_model.sv ----
// Behavioural glass panel watching the backplane and frontplane codes.
// Assumes level codes on a common scale; a segment counts as lit when it
// sees a swing of two codes or more, which only a selected on segment gets.
`timescale 1ns/1ps
module lcd_glass_model import lcd_pkg::*; (
  input wire logic i_clk,
  input wire logic i_clr,
  input wire logic [BP_NUM-1:0][1:0] i_backplane,
  input wire logic [FP_NUM-1:0][1:0] i_frontplane,
  output logic [FP_NUM*BP_NUM-1:0] o_lit
);
  int d;
  // The glass sees voltage whether or not the enable is high.
  always @(posedge i_clk) begin
    for (int f = 0; f < FP_NUM; f++) begin
      for (int b = 0; b < BP_NUM; b++) begin
        d = int'(i_backplane[b]) - int'(i_frontplane[f]);
        if (i_clr) begin
          o_lit[f*BP_NUM+b] <= 1'b0;
        end else if (d >= 2 || d <= -2) begin
          o_lit[f*BP_NUM+b] <= 1'b1;
        end
      end
    end
  end
endmodule // lcd_glass_model

// ---- tb/segment_lcd_driver_tb.sv ----
// Self-checking bench for the segment LCD driver with a glass model.
// Assumes short slot parameters so every mode runs in a few frames.
`timescale 1ns/1ps
module segment_lcd_driver_tb import lcd_pkg::*;;
  localparam int S2 = 4;
  localparam int S3 = 3;
  localparam int S4 = 2;
  logic i_clk, i_rst_n, i_wr, i_rd, i_wait, clr, rd_seen, o_drv_en;
  logic [7:0] i_addr, i_wdata, o_rdata;
  logic [BP_NUM-1:0][1:0] o_backplane;
  logic [FP_NUM-1:0][1:0] o_frontplane;
  logic [71:0] lit;
  logic [7:0] rd_q[$];
  logic [7:0] ram[12];
  int err_total, cmp_count, seed;
  segment_lcd_driver #(.SLOT_2BP_P(S2), .SLOT_3BP_P(S3),
    .SLOT_4BP_P(S4)) segment_lcd_driver_inst (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .i_wait(i_wait), .o_rdata(o_rdata), .o_drv_en(o_drv_en),
    .o_backplane(o_backplane), .o_frontplane(o_frontplane));
  lcd_glass_model lcd_glass_model_inst (.i_clk(i_clk), .i_clr(clr),
    .i_backplane(o_backplane), .i_frontplane(o_frontplane), .o_lit(lit));
  always #10 i_clk = ~i_clk;
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmp_pin(input logic [71:0] got, input logic [71:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    cmp_pin(72'(got), 72'(exp));
  endtask
  // Strobes are left as set; the next call or an idle call replaces them.
  task automatic bus(input logic w, input logic r, input logic [7:0] a,
      input logic [7:0] d);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  always @(posedge i_clk) rd_seen <= i_rd;
  always @(negedge i_clk) begin
    if (rd_seen === 1'b1) begin
      cmp_rd(o_rdata, rd_q.pop_front());
    end
  end
  task automatic run(input logic [1:0] m, input logic h);
    int n, top, len, nbp;
    logic [7:0] c;
    logic [71:0] exp;
    logic [FP_NUM-1:0][1:0] fexp;
    top = (m == MODE_2BP_HALF) ? 2 : 3;
    nbp = (m == MODE_3BP) ? 3 : (m == MODE_4BP) ? 4 : 2;
    len = (m == MODE_3BP) ? S3 : (m == MODE_4BP) ? S4 : S2;
    len = len * BUS_DIV * (h ? 2 : 1);
    @(posedge i_clk);
    c = {4'h0, h, m, 1'b0};
    for (int k = 0; k < RAM_BYTES; k++) begin
      ram[k] = 8'($random(seed));
      bus(1'b1, 1'b0, RAM_BASE + 8'(k), ram[k]);
    end
    bus(1'b1, 1'b0, CTRL_ADDR, c);
    for (int k = 0; k < RAM_BYTES; k++) rd(RAM_BASE + 8'(k), ram[k]);
    rd(CTRL_ADDR, c);
    bus(1'b1, 1'b0, CTRL_ADDR, c | 8'h01);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    @(posedge i_clk);
    #1;
    cmp_pin(72'(o_drv_en), 72'd1);
    cmp_pin(72'(o_backplane), 72'({6'h15, 2'(top)}));
    for (int j = 0; j < FP_NUM; j++) begin
      fexp[j] = ram[j/2][(j%2)*4] ? 2'd0 : 2'(top - 1);
    end
    cmp_pin(72'(o_frontplane), 72'(fexp));
    n = 0;
    while (o_backplane[1] !== 2'(top) && n < 5000) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    n = 0;
    while (o_backplane[1] === 2'(top) && n < 5000) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    cmp_pin(72'(n), 72'(len));
    clr <= 1'b1;
    @(posedge i_clk);
    clr <= 1'b0;
    repeat (nbp * len + 4) @(posedge i_clk);
    for (int j = 0; j < FP_NUM; j++) begin
      for (int b = 0; b < BP_NUM; b++) begin
        exp[j*4+b] = ram[j/2][(j%2)*4+b] && (b < nbp);
      end
    end
    cmp_pin(lit, exp);
    bus(1'b1, 1'b0, CTRL_ADDR, c);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    #1;
    cmp_pin(72'({o_drv_en, o_backplane, o_frontplane}), 72'd0);
  endtask
  initial begin
    i_clk = 1'b0;
    i_rst_n = 1'b0;
    {i_wr, i_rd, i_wait, clr} = 4'h0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    seed = 34;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(CTRL_ADDR, CTRL_RST);
    rd(8'h4C, 8'h00);
    bus(1'b1, 1'b0, RAM_LAST, 8'h5A);
    rd(RAM_LAST, 8'h5A);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    #1;
    cmp_pin(72'(o_drv_en), 72'd0);
    for (int m = 0; m < 8; m++) run(2'(m), 1'(m >> 2));
    @(posedge i_clk);
    bus(1'b1, 1'b0, CTRL_ADDR, 8'h01);
    repeat (4) bus(1'b0, 1'b0, 8'h00, 8'h00);
    i_wait <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    cmp_pin(72'({o_drv_en, o_backplane}), 72'd0);
    @(posedge i_clk);
    i_wait <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
    cmp_pin(72'(o_drv_en), 72'd1);
    conclude();
  end
  // A hang is cut short well beyond the few thousand cycles the run needs.
  initial begin
    #1_200_000;
    err_total++;
    conclude();
  end
endmodule // segment_lcd_driver_tb
